// ### src/csf_map.vh
// Register offsets, field positions and reset values of the clocked serial unit
`ifndef CSF_MAP_VH
`define CSF_MAP_VH

`define CSF_OFF_MAIN 5'h00
`define CSF_OFF_FMT 5'h04
`define CSF_OFF_WLEN 5'h08
`define CSF_OFF_STAT 5'h0c
`define CSF_OFF_TXBUF 5'h10
`define CSF_OFF_RXBUF 5'h14

`define CSF_MAIN_PWR 7
`define CSF_MAIN_TXE 6
`define CSF_MAIN_RXE 5
`define CSF_MAIN_DIR 4
`define CSF_MAIN_MASK 8'hf0

`define CSF_FMT_CKP 4
`define CSF_FMT_DAP 3
`define CSF_FMT_CKS_HI 2
`define CSF_FMT_CKS_LO 0
`define CSF_FMT_MASK 8'h1f
`define CSF_CKS_SLAVE 3'h7

`define CSF_WLEN_MASK 8'h0f
`define CSF_WLEN_TOP 3
`define CSF_LEN_BASE 5'h08
`define CSF_LEN_MAX 5'h10

`define CSF_STAT_BUSY 7

`define CSF_RST_MAIN 8'h00
`define CSF_RST_FMT 8'h00
`define CSF_RST_WLEN 8'h00
`define CSF_RST_BUF 16'h0000

`endif

// ### src/csf_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module csf_sync #(
    parameter WIDTH = 2
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire [WIDTH-1:0] d_i,
    output reg [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    integer i;

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_r <= {WIDTH{1'b0}};
            s2_r <= {WIDTH{1'b0}};
            s3_r <= {WIDTH{1'b0}};
            q_o <= {WIDTH{1'b0}};
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // A change counts only once stages two and three agree
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    q_o[i] <= s3_r[i];
                end
            end
        end
    end
endmodule

// ### src/csf_clkdiv.v
// Serial clock divider producing half-period enable pulses
`timescale 1ns/100ps
module csf_clkdiv #(
    parameter CW = 7
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire run_i,
    input wire [2:0] sel_i,
    output reg tick_o
);
    reg [CW-1:0] cnt_r;
    wire [CW-1:0] limit;

    // Half period is 2^sel cycles, so the full clock is fxx/2 .. fxx/128
    assign limit = {CW{1'b1}} >> (3'd7 - sel_i);

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= {CW{1'b0}};
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_r <= {CW{1'b0}};
            tick_o <= 1'b0;
        end else if (cnt_r == limit) begin
            cnt_r <= {CW{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule

// ### src/csf_top.v
// Clocked serial unit: format and clock control with transfer engine
//
// Behaviour
// - Format/clock register is 8 bits, byte writable, resets to zero.
// - Word length register is 8 bits, byte writable, resets to zero.
// - Polarity and phase bits pick transfer type 1 (00) to 4 (11).
// - Master clock is fxx divided by 2..128 for select codes 000..110.
// - Format register writes take effect only while power-on is 0.
// - Length writes only when power-on is 0 or transmit and receive off.
// - Length codes 0..7 give 8..15 bits; top bit set gives 16.
// - Short words sit right aligned at bit 0 in both buffers.
// - Receive buffer bits above the length read zero after a transfer.
// - Transmit buffer bits above the length never reach the output.
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
`include "csf_map.vh"
module csf_top (
    input wire clk_i,
    input wire arst_n_i,
    input wire [4:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    input wire sck_i,
    output reg sck_o,
    output reg sck_oe_o,
    input wire si_i,
    output reg so_o,
    output reg so_oe_o
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;

    reg [7:0] main_r;
    reg [7:0] fmt_r;
    reg [7:0] wlen_r;
    reg [15:0] txbuf_r;
    reg [15:0] rxbuf_r;
    reg [15:0] txsh_r;
    reg [15:0] rxacc_r;
    reg [15:0] rxacc_nxt;
    reg [4:0] ecnt_r;
    reg [1:0] state_r;
    reg sck_f_d_r;
    reg [31:0] rdmux;
    reg so_nxt;

    wire [1:0] pin_f;
    wire tick;
    wire pwr = main_r[`CSF_MAIN_PWR];
    wire txe = main_r[`CSF_MAIN_TXE];
    wire rxe = main_r[`CSF_MAIN_RXE];
    wire lsb_first = main_r[`CSF_MAIN_DIR];
    wire cpol = fmt_r[`CSF_FMT_CKP];
    wire dap = fmt_r[`CSF_FMT_DAP];
    wire [2:0] cks = fmt_r[`CSF_FMT_CKS_HI:`CSF_FMT_CKS_LO];
    wire master = (cks != `CSF_CKS_SLAVE);
    wire busy = (state_r == ST_RUN);

    // Length from the four-bit field
    wire [4:0] len = wlen_r[`CSF_WLEN_TOP] ? `CSF_LEN_MAX :
        (`CSF_LEN_BASE + {2'b00, wlen_r[2:0]});
    wire [16:0] len_mask17 = (17'h00001 << len) - 17'h00001;
    wire [15:0] len_mask = len_mask17[15:0];

    // Bus handshake: a request is taken on the edge where waitrequest is low
    wire take = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    wire wr_take = avs_write_i && !avs_waitrequest_o;
    wire rd_take = avs_read_i && !avs_waitrequest_o;
    wire be0 = avs_byteenable_i[0];
    wire be1 = avs_byteenable_i[1];
    wire wr_main = wr_take && be0 && (avs_address_i == `CSF_OFF_MAIN);
    wire wr_fmt = wr_take && be0 && (avs_address_i == `CSF_OFF_FMT);
    wire wr_wlen = wr_take && be0 && (avs_address_i == `CSF_OFF_WLEN);
    wire wr_tx = wr_take && (avs_address_i == `CSF_OFF_TXBUF);
    wire rd_rx = rd_take && (avs_address_i == `CSF_OFF_RXBUF);

    // Transmit starts a transfer; with transmit off a dummy receive read does
    wire start = !busy && pwr && ((wr_tx && txe) || (rd_rx && rxe && !txe));

    // Bit counter and buffer bit position for the current edge
    wire [3:0] bit_n = ecnt_r[4:1];
    wire [3:0] bit_n1 = bit_n + 4'h1;
    wire [4:0] len_m1 = len - 5'h01;
    wire [3:0] pos_n = lsb_first ? bit_n : (len_m1[3:0] - bit_n);
    wire [3:0] pos_n1 = lsb_first ? bit_n1 : (len_m1[3:0] - bit_n1);
    wire [3:0] pos_0 = lsb_first ? 4'h0 : len_m1[3:0];
    wire [4:0] last_e = {len_m1[3:0], 1'b1};

    // Serial clock edge: divider tick as master, filtered pin edge as slave
    wire slv_edge = (pin_f[0] != sck_f_d_r);
    wire sck_edge = busy && (master ? tick : slv_edge);
    // Phase 0 samples on even edges, phase 1 on odd edges
    wire samp = sck_edge && (ecnt_r[0] == dap);
    wire last = sck_edge && (ecnt_r == last_e);

    csf_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .d_i({si_i, sck_i}),
        .q_o(pin_f)
    );

    csf_clkdiv #(
        .CW(7)
    ) u_div (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .run_i(busy && master),
        .sel_i(cks),
        .tick_o(tick)
    );

    // Next receive accumulator with the sampled bit folded in
    always @* begin
        rxacc_nxt = rxacc_r;
        if (samp) begin
            rxacc_nxt[pos_n] = pin_f[1];
        end
    end

    // Next serial output bit
    always @* begin
        so_nxt = so_o;
        if (sck_edge && !samp) begin
            if (dap) begin
                so_nxt = txsh_r[pos_n];
            end else if (!last && ({1'b0, bit_n1} < len)) begin
                so_nxt = txsh_r[pos_n1];
            end
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always @* begin
        rdmux = 32'h00000000;
        case (avs_address_i)
            `CSF_OFF_MAIN: rdmux[7:0] = main_r;
            `CSF_OFF_FMT: rdmux[7:0] = fmt_r;
            `CSF_OFF_WLEN: rdmux[7:0] = wlen_r;
            `CSF_OFF_STAT: rdmux[`CSF_STAT_BUSY] = busy;
            `CSF_OFF_TXBUF: rdmux[15:0] = txbuf_r;
            `CSF_OFF_RXBUF: rdmux[15:0] = rxbuf_r;
            default: rdmux = 32'h00000000;
        endcase
    end

    // Bus slave: one wait cycle, then a single low cycle of waitrequest
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
            if (avs_read_i && avs_waitrequest_o) begin
                avs_readdata_o <= rdmux;
            end else if (take) begin
                avs_readdata_o <= 32'h00000000;
            end
        end
    end

    // Control registers
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            main_r <= `CSF_RST_MAIN;
            fmt_r <= `CSF_RST_FMT;
            wlen_r <= `CSF_RST_WLEN;
            txbuf_r <= `CSF_RST_BUF;
        end else begin
            if (wr_main) begin
                main_r <= avs_writedata_i[7:0] & `CSF_MAIN_MASK;
            end
            // Locked while powered so the live format never changes mid-word
            if (wr_fmt && !pwr) begin
                fmt_r <= avs_writedata_i[7:0] & `CSF_FMT_MASK;
            end
            if (wr_wlen && (!pwr || (!txe && !rxe))) begin
                wlen_r <= avs_writedata_i[7:0] & `CSF_WLEN_MASK;
            end
            if (wr_tx && be0) begin
                txbuf_r[7:0] <= avs_writedata_i[7:0];
            end
            if (wr_tx && be1) begin
                txbuf_r[15:8] <= avs_writedata_i[15:8];
            end
        end
    end

    // Transfer engine
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ST_IDLE;
            ecnt_r <= 5'h00;
            txsh_r <= `CSF_RST_BUF;
            rxacc_r <= `CSF_RST_BUF;
            rxbuf_r <= `CSF_RST_BUF;
            sck_f_d_r <= 1'b0;
            sck_o <= 1'b0;
            sck_oe_o <= 1'b0;
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
        end else begin
            sck_f_d_r <= pin_f[0];
            sck_oe_o <= pwr && master;
            so_oe_o <= pwr && txe;
            if (!pwr) begin
                // Power off aborts any word in flight
                state_r <= ST_IDLE;
                ecnt_r <= 5'h00;
                sck_o <= cpol;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        sck_o <= cpol;
                        if (start && wr_tx) begin
                            state_r <= ST_RUN;
                            ecnt_r <= 5'h00;
                            rxacc_r <= 16'h0000;
                            // Tx bits above the length are dropped here
                            txsh_r <= avs_writedata_i[15:0] & len_mask;
                            if (!dap) begin
                                so_o <= avs_writedata_i[pos_0];
                            end
                        end else if (start) begin
                            state_r <= ST_RUN;
                            ecnt_r <= 5'h00;
                            rxacc_r <= 16'h0000;
                            txsh_r <= txbuf_r & len_mask;
                            if (!dap) begin
                                so_o <= txbuf_r[pos_0];
                            end
                        end
                    end
                    ST_RUN: begin
                        if (sck_edge) begin
                            ecnt_r <= ecnt_r + 5'h01;
                            rxacc_r <= rxacc_nxt;
                            so_o <= so_nxt;
                            if (master) begin
                                sck_o <= ~sck_o;
                            end
                        end
                        if (last) begin
                            state_r <= ST_IDLE;
                            rxbuf_r <= rxacc_nxt & len_mask;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ### dv/csf_top_assertions.sv
// Port-level assertions for the clocked serial unit
`timescale 1ns/100ps
`include "csf_map.vh"
module csf_chk (
    input wire clk_i,
    input wire arst_n_i,
    input wire [4:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire sck_i,
    input wire sck_o,
    input wire sck_oe_o,
    input wire si_i,
    input wire so_o,
    input wire so_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    wire req = avs_read_i || avs_write_i;
    wire rd_ok = avs_read_i && !avs_waitrequest_o;
    property p_rst; disable iff (1'b0) !arst_n_i |-> !sck_oe_o && !so_oe_o && avs_waitrequest_o; endproperty
    a_rst: assert property (p_rst) else $error("outputs active in reset");
    property p_ans; req && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    a_ans: assert property (p_ans) else $error("no answer one cycle after request");
    property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    a_one: assert property (p_one) else $error("wait low longer than a cycle");
    property p_idle; !req |=> avs_waitrequest_o; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_fmt_hi; rd_ok && avs_address_i == `CSF_OFF_FMT |-> avs_readdata_o[31:5] == 27'h0; endproperty
    a_fmt_hi: assert property (p_fmt_hi) else $error("format upper bits set");
    property p_len_hi; rd_ok && avs_address_i == `CSF_OFF_WLEN |-> avs_readdata_o[31:4] == 28'h0; endproperty
    a_len_hi: assert property (p_len_hi) else $error("length upper bits set");
    // Master data may only move with its own clock or at the start write
    property p_so_edge; sck_oe_o && so_oe_o && $changed(so_o) |-> $changed(sck_o) || $past(avs_write_i); endproperty
    a_so_edge: assert property (p_so_edge) else $error("data moved off clock edge");
    property p_slv; $changed(sck_o) |-> sck_oe_o || $past(sck_oe_o) || $past(avs_write_i) || $past(avs_write_i, 2);
    endproperty
    a_slv: assert property (p_slv) else $error("clock driven in slave mode");
endmodule

bind csf_top csf_chk u_chk (.*);

// ### dv/csf_peer.sv
// Far-side serial device: answers a master or supplies the clock as master
`timescale 1ns/100ps
module csf_peer (
    input wire clk_i,
    input wire on_i,
    input wire gen_i,
    input wire cpol_i,
    input wire cpha_i,
    input wire lsb_i,
    input wire [4:0] len_i,
    input wire [15:0] word_i,
    input wire dsck_i,
    input wire so_i,
    output reg sck_o,
    output wire si_o,
    output reg [15:0] got_o
);
    integer e = 0;
    reg pat_r = 1'b0;
    wire sck = gen_i ? sck_o : dsck_i;
    function integer idx(input integer n);
        idx = lsb_i ? n : len_i - 1 - n;
    endfunction
    // Released line toggles so a stale bit cannot pass for data
    // With phase 1 bit k is driven on edge 2k+1, with phase 0 on edge 2k
    assign si_o = (on_i && (e - cpha_i) / 2 < len_i) ? word_i[idx((e - cpha_i) / 2)] : pat_r;
    initial sck_o = 1'b0;
    initial got_o = 16'h0000;
    always @(posedge clk_i) pat_r <= ~pat_r;
    always @(posedge on_i) begin
        e = 0;
        got_o = 16'h0000;
        // Offset keeps the external clock edges away from the system clock edge
        if (gen_i) begin
            #25;
            repeat (2 * len_i) #1000 sck_o = ~sck_o;
        end
    end
    always @(sck) if (on_i) begin
        e = e + 1;
        if ((e + cpha_i) % 2 == 1) got_o[idx((e - 1 - cpha_i) / 2)] = so_i;
    end
endmodule

// ### dv/tb.sv
// Self-checking bench for the clocked serial unit
`timescale 1ns/100ps
`include "csf_map.vh"
module tb;
    reg clk_i = 1'b0;
    reg arst_n_i = 1'b1;
    reg [4:0] avs_address_i = 5'h00;
    reg avs_read_i = 1'b0;
    reg avs_write_i = 1'b0;
    reg [31:0] avs_writedata_i = 32'h0;
    reg [3:0] avs_byteenable_i = 4'hf;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, sck_i, sck_o, sck_oe_o, si_i, so_o, so_oe_o;
    reg on_r = 1'b0, gen_r = 1'b0, cpol_r = 1'b0, cpha_r = 1'b0, lsb_r = 1'b0;
    reg [4:0] len_r = 5'h08;
    reg [15:0] word_r = 16'h0;
    wire [15:0] got;
    integer mismatches = 0, comparisons = 0, i;
    reg [31:0] seed = 32'h042b, q;
    csf_top u_csf_top (.*);
    csf_peer u_csf_peer (.clk_i(clk_i), .on_i(on_r), .gen_i(gen_r), .cpol_i(cpol_r), .cpha_i(cpha_r),
        .lsb_i(lsb_r), .len_i(len_r), .word_i(word_r), .dsck_i(sck_o), .so_i(so_o), .sck_o(sck_i),
        .si_o(si_i), .got_o(got));
    initial forever #50 clk_i = ~clk_i;
    function [31:0] rnd;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction
    task check(input [31:0] s, input [31:0] x);
        comparisons = comparisons + 1;
        if (s !== x) begin
            mismatches = mismatches + 1;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task bus(input w, input [4:0] a, input [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task xfer(input [2:0] sel, input [3:0] code);
        integer n;
        reg p;
        reg [15:0] tx;
        reg [31:0] m;
        reg ro;
        m = (32'h1 << (code[3] ? 16 : 8 + code)) - 32'h1;
        len_r = code[3] ? 5'h10 : 5'h08 + code;
        // One run is receive only, started by a dummy read of the receive buffer
        ro = (sel == 3'h3) && (code == 4'h7);
        bus(1'b1, `CSF_OFF_MAIN, 32'h0);
        q = rnd();
        bus(1'b1, `CSF_OFF_FMT, {q[31:5], cpol_r, cpha_r, sel});
        bus(1'b0, `CSF_OFF_FMT, 32'h0);
        check(q, {27'h0, cpol_r, cpha_r, sel});
        q = rnd();
        bus(1'b1, `CSF_OFF_WLEN, {q[31:4], code});
        bus(1'b0, `CSF_OFF_WLEN, 32'h0);
        check(q, {28'h0, code});
        bus(1'b1, `CSF_OFF_MAIN, {24'h0, 1'b1, !ro, 1'b1, lsb_r, 4'h0});
        bus(1'b1, `CSF_OFF_FMT, {27'h0, ~cpol_r, ~cpha_r, ~sel});
        bus(1'b0, `CSF_OFF_FMT, 32'h0);
        check(q, {27'h0, cpol_r, cpha_r, sel});
        bus(1'b1, `CSF_OFF_WLEN, {28'h0, ~code});
        bus(1'b0, `CSF_OFF_WLEN, 32'h0);
        check(q, {28'h0, code});
        check({31'h0, sck_oe_o}, {31'h0, sel != 3'h7});
        check({31'h0, so_oe_o}, {31'h0, !ro});
        if (sel != 3'h7) check({31'h0, sck_o}, {31'h0, cpol_r});
        q = rnd();
        word_r = q[15:0];
        gen_r = sel == 3'h7;
        on_r <= 1'b1;
        q = rnd();
        tx = q[15:0];
        if (ro) begin
            bus(1'b0, `CSF_OFF_RXBUF, 32'h0);
        end else begin
            bus(1'b1, `CSF_OFF_TXBUF, {16'h0, tx});
        end
        if (sel != 3'h7) begin
            repeat (2) begin
                p = sck_o;
                n = 0;
                while (sck_o === p && n < 999) begin
                    @(posedge clk_i);
                    #1;
                    n = n + 1;
                end
            end
            check(n, 1 << sel);
        end
        n = 0;
        q = 32'h80;
        while (q[7] === 1'b1 && n < 2000) begin
            bus(1'b0, `CSF_OFF_STAT, 32'h0);
            n = n + 1;
        end
        // A poll that runs out leaves busy set and counts as a mismatch
        check({31'h0, q[7]}, 32'h0);
        bus(1'b0, `CSF_OFF_RXBUF, 32'h0);
        // Fast master divisions outrun the input filter, so receive data is not judged there
        if (sel > 3'h2) check(q, word_r & m);
        if (!ro) check({16'h0, got}, tx & m);
        on_r <= 1'b0;
    endtask
    initial begin
        arst_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        bus(1'b0, `CSF_OFF_FMT, 32'h0);
        check(q, 32'h0);
        bus(1'b0, `CSF_OFF_WLEN, 32'h0);
        check(q, 32'h0);
        bus(1'b1, 5'h1c, 32'hff);
        bus(1'b0, 5'h1c, 32'h0);
        check(q, 32'h0);
        // A control write without the low byte enable must be ignored
        avs_byteenable_i <= 4'he;
        bus(1'b1, `CSF_OFF_FMT, 32'h1f);
        avs_byteenable_i <= 4'hf;
        bus(1'b0, `CSF_OFF_FMT, 32'h0);
        check(q, 32'h0);
        for (i = 0; i < 16; i = i + 1) begin
            q = rnd();
            cpol_r = i[1] & (i != 15);
            cpha_r = i[0];
            lsb_r = q[0];
            xfer(i < 7 ? i[2:0] : (i == 15 ? 3'h7 : 3'h3), i < 7 ? q[4:1] : (i == 15 ? 4'hc : i[3:0] - 4'h7));
        end
        give_verdict;
    end
    initial begin
        #3000000;
        mismatches = mismatches + 1;
        give_verdict;
    end
endmodule
